/* File: hdl/mpm_pkg.sv */
// Shared constants and types for the registered 16x16 multiplier link
`default_nettype none
package mpm_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int WORD_W   = 16;
  localparam int PROD_W   = 32;
  localparam int SIGN_BIT = 15;
  // ----------------------------------------
  // Rounding positions in the raw product
  // ----------------------------------------
  localparam int RND_BIT_FRAC = 14;
  localparam int RND_BIT_INT  = 15;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic        BIT_RST  = 1'h0;
  // ----------------------------------------
  // Result FIFO defaults
  // ----------------------------------------
  localparam int FIFO_DEPTH = 32;
  // ----------------------------------------
  // Host sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    H_IDLE,
    H_LOAD,
    H_STROBE,
    H_ENA,
    H_READ,
    H_DONE
  } mpm_hst_e;
endpackage : mpm_pkg
`default_nettype wire

/* File: hdl/mpm_link_if.sv */
// Pin-level link between the multiplier and its controlling host
`timescale 1ns/1ps
`default_nettype none
interface mpm_link_if;
  logic        clk_x;
  logic        clk_y;
  logic        clk_l;
  logic        clk_m;
  logic [15:0] x_data;
  logic        x_signed_sel;
  logic        y_signed_sel;
  logic        round_up;
  logic        product_format_shift;
  logic        output_feedthrough;
  logic        low_word_hiz;
  logic        high_word_hiz;
  logic [15:0] y_host_out;
  logic        y_host_oe;
  logic [15:0] lower_product_word;
  logic        lower_oe;
  logic [15:0] upper_product_word;
  logic        upper_oe;
  logic [15:0] y_bus;
  logic [15:0] upper_pins;
  logic        bus_clash;
  // ----------------------------------------
  // Pin resolution; an undriven bus reads 0
  // ----------------------------------------
  assign y_bus      = lower_oe ? lower_product_word : (y_host_oe ? y_host_out : 16'h0000);
  assign upper_pins = upper_oe ? upper_product_word : 16'h0000;
  assign bus_clash  = lower_oe & y_host_oe;
  modport dev (
    input  clk_x, clk_y, clk_l, clk_m, x_data, x_signed_sel, y_signed_sel,
    input  round_up, product_format_shift, output_feedthrough,
    input  low_word_hiz, high_word_hiz, y_bus,
    output lower_product_word, lower_oe, upper_product_word, upper_oe
  );
  modport host (
    output clk_x, clk_y, clk_l, clk_m, x_data, x_signed_sel, y_signed_sel,
    output round_up, product_format_shift, output_feedthrough,
    output low_word_hiz, high_word_hiz, y_host_out, y_host_oe,
    input  y_bus, upper_pins
  );
endinterface : mpm_link_if
`default_nettype wire

/* File: hdl/mpm_fifo.sv */
// Result FIFO with registered output stage
`timescale 1ns/1ps
`default_nettype none
module mpm_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
      $error("FIFO depth must be a power of two");
    end
  endgenerate
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [CW-1:0]               cnt;
    logic [WIDTH-1:0]            dout;
    logic                        dout_v;
  } mpm_fifo_s;
  mpm_fifo_s s_r;
  mpm_fifo_s s_nxt;
  logic      push;
  logic      pop;
  logic      load;
  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    push  = in_valid & in_ready;
    pop   = s_r.dout_v & out_ready;
    load  = (s_r.cnt != '0) & (~s_r.dout_v | pop);
    if (pop) begin
      s_nxt.dout_v = 1'b0;
    end
    if (load) begin
      s_nxt.dout   = s_r.mem[s_r.rd];
      s_nxt.dout_v = 1'b1;
      s_nxt.rd     = s_r.rd + 1'b1;
    end
    if (push) begin
      s_nxt.mem[s_r.wr] = in_data;
      s_nxt.wr          = s_r.wr + 1'b1;
    end
    s_nxt.cnt = s_r.cnt + CW'(push) - CW'(load);
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  // Full when the array holds DEPTH words; the output stage adds one more
  assign in_ready  = (s_r.cnt != CW'(DEPTH));
  assign out_valid = s_r.dout_v;
  assign out_data  = s_r.dout;
endmodule : mpm_fifo
`default_nettype wire

/* File: hdl/mpm_device_end.sv */
// Multiplier end: operand registers, product array, product word registers
//
// How it works
// - two independent 16-bit operand registers
// - two 16-bit product words, own drivers
// - full 32-bit product, signed or unsigned
// - feedthrough high reloads product registers every clock
// - word driver off one clock after its hiz goes high
// - no shift drops duplicate sign, doubles upper word
// - host sets shift for unsigned, mixed, integer
// - round adds one at bit 14 or 15
// - rounding adds upward, lower word shows it
// - bit 15 is sign for signed operand
// - signed, no shift: both word MSBs sign
// - host drives Y only while lower hiz
// - lower word on Y only while enabled
// - host holds upper hiz low to read
// - four strobes, one per register, capture data
// - round captured on either operand strobe
// - per-operand signedness; mixed result two's complement
`timescale 1ns/1ps
`default_nettype none
module mpm_device_end #(
  parameter int W = 16
) (
  input  wire logic    clk,
  input  wire logic    rst_n,
  mpm_link_if.dev      lnk,
  output logic [31:0]  full_product,
  output logic         product_sign
);
  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  generate
    if (W != mpm_pkg::WORD_W) begin : g_bad
      $error("Word width must match the link width");
    end
    if (mpm_pkg::PROD_W != 2 * W) begin : g_bad_prod
      $error("Product width must be twice the word width");
    end
  endgenerate

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] x_r;
    logic        xs_r;
    logic [15:0] y_r;
    logic        ys_r;
    logic        rnd_r;
    logic [15:0] upper_r;
    logic [15:0] lower_r;
    logic        upper_oe_r;
    logic        lower_oe_r;
    logic [31:0] full_r;
    logic        sign_r;
  } mpm_dev_s;

  mpm_dev_s s_r;
  mpm_dev_s s_nxt;

  logic [31:0] raw_prod;
  logic [31:0] fmt_prod;

  // ----------------------------------------
  // Product array
  // ----------------------------------------
  // Each operand is widened by one bit: its sign bit when signed,
  // zero when unsigned. One signed 17x17 product then serves all
  // four mode combinations, and mixed results come out in two's
  // complement without any correction term.
  function automatic logic signed [16:0] mpm_extend(
    input logic [15:0] v,
    input logic        v_signed
  );
    mpm_extend = {v_signed & v[mpm_pkg::SIGN_BIT], v};
  endfunction : mpm_extend

  function automatic logic [31:0] mpm_mult(
    input logic [15:0] a,
    input logic        a_signed,
    input logic [15:0] b,
    input logic        b_signed
  );
    logic signed [16:0] ea;
    logic signed [16:0] eb;
    logic signed [33:0] pr;
    ea = mpm_extend(a, a_signed);
    eb = mpm_extend(b, b_signed);
    pr = ea * eb;
    mpm_mult = pr[31:0];
  endfunction : mpm_mult

  // ----------------------------------------
  // Rounding and output format
  // ----------------------------------------
  // Rounding only ever adds; callers that need unbiased
  // rounding have to compensate outside.
  function automatic logic [31:0] mpm_format(
    input logic [31:0] p,
    input logic        shift,
    input logic        rnd
  );
    logic [31:0] inc;
    logic [31:0] rp;
    inc = '0;
    if (rnd) begin
      if (shift) begin
        inc[mpm_pkg::RND_BIT_INT] = 1'b1;
      end else begin
        inc[mpm_pkg::RND_BIT_FRAC] = 1'b1;
      end
    end
    rp = p + inc;
    if (shift) begin
      mpm_format = rp;
    end else begin
      mpm_format = {rp[30:15], rp[30], rp[14:0]};
    end
  endfunction : mpm_format

  // ----------------------------------------
  // Product word load decode
  // ----------------------------------------
  // Feedthrough loads on every clock, so the words
  // still come from flops, one cycle late
  function automatic logic mpm_word_load(
    input logic strobe,
    input logic feedthrough
  );
    mpm_word_load = strobe | feedthrough;
  endfunction : mpm_word_load

  // Pure combinational path from operand registers
  assign raw_prod = mpm_mult(s_r.x_r, s_r.xs_r, s_r.y_r, s_r.ys_r);
  assign fmt_prod = mpm_format(raw_prod, lnk.product_format_shift, s_r.rnd_r);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    // Operand X and its mode
    if (lnk.clk_x) begin
      s_nxt.x_r  = lnk.x_data;
      s_nxt.xs_r = lnk.x_signed_sel;
    end
    // Operand Y comes off the shared pins
    if (lnk.clk_y) begin
      s_nxt.y_r  = lnk.y_bus;
      s_nxt.ys_r = lnk.y_signed_sel;
    end
    // Round travels with whichever operand was loaded
    if (lnk.clk_x | lnk.clk_y) begin
      s_nxt.rnd_r = lnk.round_up;
    end
    // Product words load on their own strobe or every cycle in feedthrough
    if (mpm_word_load(lnk.clk_m, lnk.output_feedthrough)) begin
      s_nxt.upper_r = fmt_prod[31:16];
    end
    if (mpm_word_load(lnk.clk_l, lnk.output_feedthrough)) begin
      s_nxt.lower_r = fmt_prod[15:0];
    end
    // Drivers follow their hiz controls
    s_nxt.upper_oe_r = ~lnk.high_word_hiz;
    s_nxt.lower_oe_r = ~lnk.low_word_hiz;
    // Observation copy of the live array result
    s_nxt.full_r = raw_prod;
    s_nxt.sign_r = raw_prod[31];
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // The part itself has no reset; one is kept so simulation
  // starts from known words and both drivers off.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r.x_r        <= mpm_pkg::WORD_RST;
      s_r.xs_r       <= mpm_pkg::BIT_RST;
      s_r.y_r        <= mpm_pkg::WORD_RST;
      s_r.ys_r       <= mpm_pkg::BIT_RST;
      s_r.rnd_r      <= mpm_pkg::BIT_RST;
      s_r.upper_r    <= mpm_pkg::WORD_RST;
      s_r.lower_r    <= mpm_pkg::WORD_RST;
      s_r.upper_oe_r <= mpm_pkg::BIT_RST;
      s_r.lower_oe_r <= mpm_pkg::BIT_RST;
      s_r.full_r     <= '0;
      s_r.sign_r     <= mpm_pkg::BIT_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign lnk.upper_product_word = s_r.upper_r;
  assign lnk.upper_oe           = s_r.upper_oe_r;
  assign lnk.lower_product_word = s_r.lower_r;
  assign lnk.lower_oe           = s_r.lower_oe_r;
  assign full_product           = s_r.full_r;
  assign product_sign           = s_r.sign_r;
endmodule : mpm_device_end
`default_nettype wire

/* File: hdl/mpm_host_end.sv */
// Host end: sequences one multiply per command and queues results
`timescale 1ns/1ps
`default_nettype none
module mpm_host_end #(
  parameter int DEPTH = 32
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  mpm_link_if.host         lnk,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [15:0] cmd_x,
  input  wire logic [15:0] cmd_y,
  input  wire logic        cmd_x_signed,
  input  wire logic        cmd_y_signed,
  input  wire logic        cmd_round,
  input  wire logic        cmd_shift,
  input  wire logic        cmd_feedthrough,
  output logic             res_valid,
  input  wire logic        res_ready,
  output logic [31:0]      res_data
);
  typedef struct packed {
    mpm_pkg::mpm_hst_e st;
    logic              rdy;
    logic              ck_x;
    logic              ck_y;
    logic              ck_l;
    logic              ck_m;
    logic [15:0]       x;
    logic [15:0]       y;
    logic              y_oe;
    logic              xs;
    logic              ys;
    logic              rnd;
    logic              shift;
    logic              ft;
    logic              lo_hiz;
    logic              hi_hiz;
  } mpm_host_s;
  mpm_host_s   s_r;
  mpm_host_s   s_nxt;
  logic        f_ready;
  logic        push;
  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    s_nxt      = s_r;
    s_nxt.ck_x = 1'b0;
    s_nxt.ck_y = 1'b0;
    s_nxt.ck_l = 1'b0;
    s_nxt.ck_m = 1'b0;
    push       = 1'b0;
    unique case (s_r.st)
      mpm_pkg::H_IDLE: begin
        if (cmd_valid & s_r.rdy) begin
          s_nxt.st    = mpm_pkg::H_LOAD;
          s_nxt.rdy   = 1'b0;
          s_nxt.x     = cmd_x;
          s_nxt.y     = cmd_y;
          s_nxt.xs    = cmd_x_signed;
          s_nxt.ys    = cmd_y_signed;
          s_nxt.rnd   = cmd_round;
          s_nxt.shift = cmd_shift;
          s_nxt.ft    = cmd_feedthrough;
          s_nxt.y_oe  = 1'b1;
          s_nxt.ck_x  = 1'b1;
          s_nxt.ck_y  = 1'b1;
        end
      end
      mpm_pkg::H_LOAD: begin
        s_nxt.st   = mpm_pkg::H_STROBE;
        s_nxt.y_oe = 1'b0;
        s_nxt.ck_l = 1'b1;
        s_nxt.ck_m = 1'b1;
      end
      mpm_pkg::H_STROBE: begin
        s_nxt.st     = mpm_pkg::H_ENA;
        s_nxt.lo_hiz = 1'b0;
        s_nxt.hi_hiz = 1'b0;
      end
      mpm_pkg::H_ENA: begin
        s_nxt.st = mpm_pkg::H_READ;
      end
      mpm_pkg::H_READ: begin
        // Waits here while the result FIFO is full
        push = f_ready;
        if (f_ready) begin
          s_nxt.st     = mpm_pkg::H_DONE;
          s_nxt.lo_hiz = 1'b1;
          s_nxt.hi_hiz = 1'b1;
        end
      end
      mpm_pkg::H_DONE: begin
        // Gap lets the device driver turn off before Y is driven again
        s_nxt.st  = mpm_pkg::H_IDLE;
        s_nxt.rdy = 1'b1;
      end
      default: begin
        s_nxt.st = mpm_pkg::H_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r        <= '0;
      s_r.st     <= mpm_pkg::H_IDLE;
      s_r.rdy    <= 1'b1;
      s_r.lo_hiz <= 1'b1;
      s_r.hi_hiz <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end
  // ----------------------------------------
  // Result queue
  // ----------------------------------------
  mpm_fifo #(
    .WIDTH (32),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (push),
    .in_ready  (f_ready),
    .in_data   ({lnk.upper_pins, lnk.y_bus}),
    .out_valid (res_valid),
    .out_ready (res_ready),
    .out_data  (res_data)
  );
  // ----------------------------------------
  // Link outputs
  // ----------------------------------------
  assign cmd_ready                = s_r.rdy;
  assign lnk.clk_x                = s_r.ck_x;
  assign lnk.clk_y                = s_r.ck_y;
  assign lnk.clk_l                = s_r.ck_l;
  assign lnk.clk_m                = s_r.ck_m;
  assign lnk.x_data               = s_r.x;
  assign lnk.y_host_out           = s_r.y;
  assign lnk.y_host_oe            = s_r.y_oe;
  assign lnk.x_signed_sel         = s_r.xs;
  assign lnk.y_signed_sel         = s_r.ys;
  assign lnk.round_up             = s_r.rnd;
  assign lnk.product_format_shift = s_r.shift;
  assign lnk.output_feedthrough   = s_r.ft;
  assign lnk.low_word_hiz         = s_r.lo_hiz;
  assign lnk.high_word_hiz        = s_r.hi_hiz;
endmodule : mpm_host_end
`default_nettype wire

/* File: tb/mpm_link_properties.sv */
// Concurrent checks on the multiplier link pins
`timescale 1ns/1ps
`default_nettype none
module mpm_link_properties (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        clk_x,
  input wire logic        clk_y,
  input wire logic        clk_l,
  input wire logic        clk_m,
  input wire logic [15:0] x_data,
  input wire logic        x_signed_sel,
  input wire logic        y_signed_sel,
  input wire logic        round_up,
  input wire logic        product_format_shift,
  input wire logic        output_feedthrough,
  input wire logic        low_word_hiz,
  input wire logic        high_word_hiz,
  input wire logic        y_host_oe,
  input wire logic [15:0] lower_product_word,
  input wire logic        lower_oe,
  input wire logic [15:0] upper_product_word,
  input wire logic        upper_oe,
  input wire logic [15:0] y_bus,
  input wire logic        bus_clash
);
  // ----------------------------------------
  // Operand mirror and expected words
  // ----------------------------------------
  logic [15:0] x_m;
  logic [15:0] y_m;
  logic        xs_m;
  logic        ys_m;
  logic        rnd_m;
  logic [31:0] fmt_w;
  logic [15:0] fmt_hi;
  logic [15:0] fmt_lo;
  function automatic logic [31:0] fmt(input logic [15:0] a, input logic sa, input logic [15:0] b,
                                      input logic sb, input logic r, input logic s);
    logic [31:0] p;
    p = {{16{sa & a[15]}}, a} * {{16{sb & b[15]}}, b};
    p = p + (r ? (s ? 32'h0000_8000 : 32'h0000_4000) : 32'h0000_0000);
    return s ? p : {p[30:15], p[30], p[14:0]};
  endfunction : fmt
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      x_m   <= 16'h0000;
      y_m   <= 16'h0000;
      xs_m  <= 1'b0;
      ys_m  <= 1'b0;
      rnd_m <= 1'b0;
    end else begin
      if (clk_x) begin
        x_m  <= x_data;
        xs_m <= x_signed_sel;
      end
      if (clk_y) begin
        y_m  <= y_bus;
        ys_m <= y_signed_sel;
      end
      if (clk_x | clk_y) begin
        rnd_m <= round_up;
      end
    end
  end
  assign fmt_w  = fmt(x_m, xs_m, y_m, ys_m, rnd_m, product_format_shift);
  assign fmt_hi = fmt_w[31:16];
  assign fmt_lo = fmt_w[15:0];
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_up_load; clk_m || output_feedthrough; endsequence
  sequence s_lo_load; clk_l || output_feedthrough; endsequence
  property p_up_value; s_up_load |=> upper_product_word == $past(fmt_hi); endproperty
  property p_lo_value; s_lo_load |=> lower_product_word == $past(fmt_lo); endproperty
  property p_up_hold; !clk_m && !output_feedthrough |=> $stable(upper_product_word); endproperty
  property p_lo_hold; !clk_l && !output_feedthrough |=> $stable(lower_product_word); endproperty
  property p_up_oe; upper_oe == !$past(high_word_hiz); endproperty
  property p_lo_oe; lower_oe == !$past(low_word_hiz); endproperty
  property p_no_clash; !bus_clash; endproperty
  property p_y_drive; y_host_oe |-> low_word_hiz && !lower_oe; endproperty
  a_up_value: assert property (p_up_value) else $error("upper word wrong");
  a_lo_value: assert property (p_lo_value) else $error("lower word wrong");
  a_up_hold: assert property (p_up_hold) else $error("upper word moved");
  a_lo_hold: assert property (p_lo_hold) else $error("lower word moved");
  a_up_oe: assert property (p_up_oe) else $error("upper driver wrong");
  a_lo_oe: assert property (p_lo_oe) else $error("lower driver wrong");
  a_no_clash: assert property (p_no_clash) else $error("shared pins clash");
  a_y_drive: assert property (p_y_drive) else $error("host drove pins");
  c_feed: cover property (output_feedthrough && clk_m);
endmodule : mpm_link_properties
`default_nettype wire

/* File: tb/registered_16x16_multiplier_bench.sv */
// Self-checking bench joining both multiplier ends
`timescale 1ns/1ps
`default_nettype none
module registered_16x16_multiplier_bench;
  // ----------------------------------------
  // Signals and helpers
  // ----------------------------------------
  logic        clk, rst_n, cmd_valid, cmd_ready, res_valid, res_ready, ok, product_sign;
  logic        cmd_x_signed, cmd_y_signed, cmd_round, cmd_shift, cmd_feedthrough;
  logic [15:0] cmd_x, cmd_y, lfsr_a, lfsr_b, xv, yv;
  logic [31:0] res_data, full_product, last_raw;
  logic [1:0]  ready_mode;
  logic [31:0] exp_q[$];
  int          err_total, total_checks, cycles, accepted;
  logic [15:0] cx[6] = '{16'h8000, 16'h8000, 16'hffff, 16'hffff, 16'h7fff, 16'h1234};
  logic [15:0] cy[6] = '{16'h8000, 16'h8000, 16'hffff, 16'h8000, 16'h8001, 16'hfedc};
  logic [4:0]  cm[6] = '{5'h0b, 5'h07, 5'h0c, 5'h0a, 5'h13, 5'h1d};
  mpm_link_if mpm_link_if_inst ();
  mpm_device_end mpm_device_end_inst (.clk(clk), .rst_n(rst_n), .lnk(mpm_link_if_inst),
    .full_product(full_product), .product_sign(product_sign));
  mpm_host_end mpm_host_end_inst (.clk(clk), .rst_n(rst_n), .lnk(mpm_link_if_inst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_x(cmd_x), .cmd_y(cmd_y), .cmd_x_signed(cmd_x_signed),
    .cmd_y_signed(cmd_y_signed), .cmd_round(cmd_round), .cmd_shift(cmd_shift),
    .cmd_feedthrough(cmd_feedthrough), .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data));
  mpm_link_properties mpm_link_properties_inst (.clk(clk), .rst_n(rst_n),
    .clk_x(mpm_link_if_inst.clk_x), .clk_y(mpm_link_if_inst.clk_y), .clk_l(mpm_link_if_inst.clk_l),
    .clk_m(mpm_link_if_inst.clk_m), .x_data(mpm_link_if_inst.x_data),
    .x_signed_sel(mpm_link_if_inst.x_signed_sel), .y_signed_sel(mpm_link_if_inst.y_signed_sel),
    .round_up(mpm_link_if_inst.round_up), .product_format_shift(mpm_link_if_inst.product_format_shift),
    .output_feedthrough(mpm_link_if_inst.output_feedthrough), .low_word_hiz(mpm_link_if_inst.low_word_hiz),
    .high_word_hiz(mpm_link_if_inst.high_word_hiz), .y_host_oe(mpm_link_if_inst.y_host_oe),
    .lower_product_word(mpm_link_if_inst.lower_product_word), .lower_oe(mpm_link_if_inst.lower_oe),
    .upper_product_word(mpm_link_if_inst.upper_product_word), .upper_oe(mpm_link_if_inst.upper_oe),
    .y_bus(mpm_link_if_inst.y_bus), .bus_clash(mpm_link_if_inst.bus_clash));
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next
  // Mode bits are {feedthrough, shift, round, y signed, x signed}
  function automatic logic [31:0] exp_res(input logic [15:0] x, input logic [15:0] y, input logic [4:0] m);
    logic [31:0] p;
    p = {{16{m[0] & x[15]}}, x} * {{16{m[1] & y[15]}}, y};
    p = p + (m[2] ? (m[3] ? 32'h0000_8000 : 32'h0000_4000) : 32'h0000_0000);
    return m[3] ? p : {p[30:15], p[30], p[14:0]};
  endfunction : exp_res
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  // Refusal shows as cmd_ready staying low past a full command spacing
  task automatic send(input logic [15:0] x, input logic [15:0] y, input logic [4:0] m, output logic okv);
    int n;
    n = 0;
    // An edge with valid low keeps two requests out of one time step
    @(posedge clk);
    #1;
    cmd_x = x;
    cmd_y = y;
    {cmd_feedthrough, cmd_shift, cmd_round, cmd_y_signed, cmd_x_signed} = m;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    okv = (cmd_ready === 1'b1);
    if (okv) begin
      exp_q.push_back(exp_res(x, y, m));
      last_raw = exp_res(x, y, {3'h2, m[1:0]});
    end
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
  endtask : send
  task automatic rnd_send(output logic okv);
    lfsr_a = lfsr_next(lfsr_a);
    xv = lfsr_a;
    lfsr_a = lfsr_next(lfsr_a);
    yv = lfsr_a;
    lfsr_a = lfsr_next(lfsr_a);
    send(xv, yv, lfsr_a[4:0] | {1'b0, ~(lfsr_a[0] & lfsr_a[1]), 3'h0}, okv);
  endtask : rnd_send
  task automatic drain(input string tname);
    int n;
    n = 0;
    ready_mode <= 2'h1;
    while (exp_q.size() != 0 && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    repeat (3) @(posedge clk);
    #1;
    check("queue_left", 32'h0, 32'(exp_q.size()));
    check("res_valid_idle", 32'h0, {31'h0, res_valid});
    check("full_product", last_raw, full_product);
    check("product_sign", {31'h0, last_raw[31]}, {31'h0, product_sign});
    $display("test %s done", tname);
  endtask : drain
  // ----------------------------------------
  // Clock, result consumer, timeout
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    #1;
    lfsr_b = lfsr_next(lfsr_b);
    res_ready = (ready_mode == 2'h1) || (ready_mode == 2'h2 && lfsr_b[0]);
  end
  always @(negedge clk) begin
    if (res_valid === 1'b1 && res_ready === 1'b1) begin
      if (exp_q.size() == 0) check("res_extra", 32'h0, 32'h1);
      else check("res_data", exp_q.pop_front(), res_data);
    end
    cycles++;
    if (cycles == 30000) begin
      err_total++;
      $display("timeout reached");
      results();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {cmd_valid, cmd_x, cmd_y, cmd_x_signed, cmd_y_signed, cmd_round, cmd_shift, cmd_feedthrough} = '0;
    res_ready = 1'b0;
    ready_mode = 2'h0;
    rst_n = 1'b0;
    lfsr_a = 16'hea06;
    lfsr_b = 16'hea06;
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    check("cmd_ready_rst", 32'h1, {31'h0, cmd_ready});
    // Extreme operands, every signedness mix, rounding in both formats
    ready_mode <= 2'h1;
    for (int i = 0; i < 6; i++) send(cx[i], cy[i], cm[i], ok);
    drain("corners");
    ready_mode <= 2'h2;
    repeat (40) rnd_send(ok);
    drain("random");
    // Consumer stalled: results pile up until the host refuses
    ready_mode <= 2'h0;
    accepted = 0;
    ok = 1'b1;
    while (ok && accepted < 40) begin
      rnd_send(ok);
      if (ok) accepted++;
    end
    // Array words, the output stage and one word held in the host
    check("fill_count", 32'(mpm_pkg::FIFO_DEPTH + 2), 32'(accepted));
    drain("fill");
    results();
  end
endmodule : registered_16x16_multiplier_bench
`default_nettype wire
